// ### design/aout_seq_pkg.sv
`default_nettype none
package aout_seq_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV_A = 8'h04;
	localparam logic [7:0] OFS_DIV_B = 8'h08;
	localparam logic [7:0] OFS_THRESH = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_LEVEL = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_FIFO_DATA = 8'h20;
	// control fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_SEQ = 1;
	localparam int CTRL_BURST = 2;
	localparam int CTRL_SRC_LO = 3;
	localparam int CTRL_CASCADE = 5;
	localparam int CTRL_SW_SYNC = 6;
	localparam int CTRL_INITIATOR = 7;
	localparam int CTRL_WIDTH = 8;
	localparam logic [1:0] SRC_RATE = 2'h0;
	localparam logic [1:0] SRC_SW = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	// buffer entry layout
	localparam int ENTRY_WIDTH = 16;
	localparam int VAL_WIDTH = 12;
	localparam int ENT_CH_LO = 12;
	localparam int ENT_GROUP_END = 14;
	localparam int ENT_BURST_END = 15;
	localparam int NUM_CH = 4;
	// fifo geometry
	localparam int FIFO_AW = 15;
	localparam int FIFO_DEPTH = 32768;
	localparam int DIV_WIDTH = 16;
	// interrupt bits
	localparam int IRQ_BITS = 4;
	localparam int IRQ_LOADED = 0;
	localparam int IRQ_BURST_DONE = 1;
	localparam int IRQ_LOW_LEVEL = 2;
	localparam int IRQ_UNDERRUN = 3;
	// reset values
	localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 8'h00;
	localparam logic [DIV_WIDTH-1:0] DIV_RST = 16'hffff;
	localparam logic [FIFO_AW-1:0] THRESH_RST = 15'h0000;
	localparam logic [IRQ_BITS-1:0] IRQ_RST = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT_SYNC = 3'b010,
		ST_RUN = 3'b100
	} seq_state_t;
endpackage
`default_nettype wire

// ### design/sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sample_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [aout_seq_pkg::ENTRY_WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [aout_seq_pkg::ENTRY_WIDTH-1:0] rd_data,
	output logic [aout_seq_pkg::FIFO_AW:0] level
);
	logic [aout_seq_pkg::ENTRY_WIDTH-1:0] mem [aout_seq_pkg::FIFO_DEPTH];
	logic [aout_seq_pkg::FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [aout_seq_pkg::FIFO_AW:0] cnt_r, cnt_nxt;
	logic do_wr, do_rd;

	// full only when the count reaches the whole depth
	assign wr_ready = !cnt_r[aout_seq_pkg::FIFO_AW];
	assign rd_valid = cnt_r != '0;
	assign rd_data = mem[rp_r];
	assign level = cnt_r;

	always_comb begin
		do_wr = wr_valid && !cnt_r[aout_seq_pkg::FIFO_AW];
		do_rd = rd_ready && rd_valid;
		wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
		rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r;
		if (do_wr && !do_rd) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (do_rd && !do_wr) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// storage has no reset: only the pointers and the count define what is valid
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wp_r] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule // sample_fifo
`default_nettype wire

// ### design/analog_output_sequencer.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module analog_output_sequencer (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic DMA_VALID,
	output logic DMA_READY,
	input wire logic [15:0] DMA_DATA,
	output logic DMA_REQ,
	input wire logic EXT_SYNC_IN,
	output logic SYNC_OUT,
	output logic [11:0] DAC0_DATA,
	output logic [11:0] DAC1_DATA,
	output logic [11:0] DAC2_DATA,
	output logic [11:0] DAC3_DATA,
	output logic [3:0] DAC_LOAD,
	output logic IRQ
);
	localparam int VW = aout_seq_pkg::VAL_WIDTH;
	localparam int NC = aout_seq_pkg::NUM_CH;
	localparam int DW = aout_seq_pkg::DIV_WIDTH;
	localparam int AW = aout_seq_pkg::FIFO_AW;
	localparam int IB = aout_seq_pkg::IRQ_BITS;

	// reset release through two flops
	logic rst_meta_r, rst_n_r;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// register file
	logic [aout_seq_pkg::CTRL_WIDTH-1:0] ctrl_r, ctrl_nxt;
	logic [DW-1:0] div_a_r, div_a_nxt, div_b_r, div_b_nxt;
	logic [AW-1:0] thr_r, thr_nxt;
	logic [IB-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
	logic [31:0] rdata_nxt;
	logic sw_pulse_r, sw_pulse_nxt;
	logic wr_en, rd_setup, fifo_sel, mapped, apb_fifo_wr;
	logic fifo_wvalid, fifo_wready, fifo_rvalid, fifo_rready;
	logic [15:0] fifo_wdata, fifo_rdata;
	logic [AW:0] level;
	logic low_level, low_d_r, running, idle_st;
	aout_seq_pkg::seq_state_t st_r, st_nxt;

	assign fifo_sel = PADDR == aout_seq_pkg::OFS_FIFO_DATA;
	// fifo port collides with DMA: the bus waits rather than the DMA
	assign PREADY = !(PSEL && PWRITE && fifo_sel && DMA_VALID);
	assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign apb_fifo_wr = wr_en && fifo_sel;

	always_comb begin
		case (PADDR)
			aout_seq_pkg::OFS_CTRL, aout_seq_pkg::OFS_DIV_A,
			aout_seq_pkg::OFS_DIV_B, aout_seq_pkg::OFS_THRESH,
			aout_seq_pkg::OFS_STATUS, aout_seq_pkg::OFS_LEVEL,
			aout_seq_pkg::OFS_IRQ_STAT, aout_seq_pkg::OFS_IRQ_MASK,
			aout_seq_pkg::OFS_FIFO_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// DMA fills the fifo first; the bus data port is a second way in
	assign fifo_wvalid = DMA_VALID || apb_fifo_wr;
	assign fifo_wdata = DMA_VALID ? DMA_DATA : PWDATA[15:0];
	assign DMA_READY = fifo_wready;
	assign low_level = level <= {1'b0, thr_r};
	assign DMA_REQ = low_level && fifo_wready;

	always_comb begin
		ctrl_nxt = ctrl_r;
		div_a_nxt = div_a_r;
		div_b_nxt = div_b_r;
		thr_nxt = thr_r;
		mask_nxt = mask_r;
		sw_pulse_nxt = 1'b0;
		stat_nxt = stat_r;
		rdata_nxt = PRDATA;
		if (wr_en) begin
			case (PADDR)
				aout_seq_pkg::OFS_CTRL: begin
					ctrl_nxt = PWDATA[aout_seq_pkg::CTRL_WIDTH-1:0];
					ctrl_nxt[aout_seq_pkg::CTRL_SW_SYNC] = 1'b0;
					sw_pulse_nxt = PWDATA[aout_seq_pkg::CTRL_SW_SYNC];
				end
				aout_seq_pkg::OFS_DIV_A: div_a_nxt = PWDATA[DW-1:0];
				aout_seq_pkg::OFS_DIV_B: div_b_nxt = PWDATA[DW-1:0];
				aout_seq_pkg::OFS_THRESH: thr_nxt = PWDATA[AW-1:0];
				aout_seq_pkg::OFS_IRQ_STAT: stat_nxt = stat_r & ~PWDATA[IB-1:0];
				aout_seq_pkg::OFS_IRQ_MASK: mask_nxt = PWDATA[IB-1:0];
				default: ;
			endcase
		end
		// a new event beats a clear in the same cycle
		stat_nxt = stat_nxt | ev;
		if (rd_setup) begin
			case (PADDR)
				aout_seq_pkg::OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
				aout_seq_pkg::OFS_DIV_A: rdata_nxt = {16'h0000, div_a_r};
				aout_seq_pkg::OFS_DIV_B: rdata_nxt = {16'h0000, div_b_r};
				aout_seq_pkg::OFS_THRESH: rdata_nxt = {17'h00000, thr_r};
				aout_seq_pkg::OFS_STATUS: rdata_nxt = {26'h0000000,
					st_r == aout_seq_pkg::ST_WAIT_SYNC, running, low_level,
					!fifo_wready, !fifo_rvalid, idle_st};
				aout_seq_pkg::OFS_LEVEL: rdata_nxt = {16'h0000, level};
				aout_seq_pkg::OFS_IRQ_STAT: rdata_nxt = {28'h0000000, stat_r};
				aout_seq_pkg::OFS_IRQ_MASK: rdata_nxt = {28'h0000000, mask_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= aout_seq_pkg::CTRL_RST;
			div_a_r <= aout_seq_pkg::DIV_RST;
			div_b_r <= aout_seq_pkg::DIV_RST;
			thr_r <= aout_seq_pkg::THRESH_RST;
			stat_r <= aout_seq_pkg::IRQ_RST;
			mask_r <= aout_seq_pkg::IRQ_RST;
			sw_pulse_r <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			div_a_r <= div_a_nxt;
			div_b_r <= div_b_nxt;
			thr_r <= thr_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			sw_pulse_r <= sw_pulse_nxt;
			PRDATA <= rdata_nxt;
		end
	end
	assign IRQ = |(stat_r & mask_r);

	// rate generators: divisor N gives one tick per N+1 clocks on A, per N+1 ticks of A on B
	logic [DW-1:0] cnt_a_r, cnt_a_nxt, cnt_b_r, cnt_b_nxt;
	logic tick_a, tick_b, rate_tick, cascade, enable;
	assign enable = ctrl_r[aout_seq_pkg::CTRL_ENABLE];
	assign cascade = ctrl_r[aout_seq_pkg::CTRL_CASCADE];
	always_comb begin
		tick_a = enable && cnt_a_r >= div_a_r;
		tick_b = tick_a && cnt_b_r >= div_b_r;
		cnt_a_nxt = (!enable || tick_a) ? '0 : cnt_a_r + 1'b1;
		cnt_b_nxt = cnt_b_r;
		if (!enable || !cascade || tick_b) begin
			cnt_b_nxt = '0;
		end else if (tick_a) begin
			cnt_b_nxt = cnt_b_r + 1'b1;
		end
		rate_tick = cascade ? tick_b : tick_a;
	end

	// clock selection and sync
	logic ext_d_r, ext_edge, seq_mode, burst_mode, out_clk, out_clk_run;
	logic trigger, sync_out_nxt;
	logic [1:0] src;
	assign seq_mode = ctrl_r[aout_seq_pkg::CTRL_SEQ];
	assign burst_mode = ctrl_r[aout_seq_pkg::CTRL_BURST];
	assign src = ctrl_r[aout_seq_pkg::CTRL_SRC_LO +: 2];
	assign ext_edge = EXT_SYNC_IN && !ext_d_r;
	assign trigger = sw_pulse_r || ext_edge;
	always_comb begin
		case (src)
			aout_seq_pkg::SRC_SW: out_clk = sw_pulse_r;
			aout_seq_pkg::SRC_EXT: out_clk = ext_edge;
			default: out_clk = rate_tick;
		endcase
		// bursts always pace on the rate generator
		if (burst_mode) begin
			out_clk = rate_tick;
		end
	end
	assign running = st_r == aout_seq_pkg::ST_RUN;
	assign idle_st = st_r == aout_seq_pkg::ST_IDLE;
	assign out_clk_run = running && out_clk;
	assign sync_out_nxt = ctrl_r[aout_seq_pkg::CTRL_INITIATOR] &&
		out_clk_run;

	// staging and converter state
	logic [VW-1:0] stage_r [NC];
	logic [VW-1:0] stage_nxt [NC];
	logic [VW-1:0] dac_r [NC];
	logic [VW-1:0] dac_nxt [NC];
	logic [NC-1:0] load_nxt;
	logic grp_done_r, grp_done_nxt, stg_burst_r, stg_burst_nxt;
	logic pop_stage, sim_load, seq_load, burst_end_load, underrun;
	logic [1:0] ent_ch;
	assign ent_ch = fifo_rdata[aout_seq_pkg::ENT_CH_LO +: 2];
	assign pop_stage = !idle_st && !seq_mode && !grp_done_r && fifo_rvalid;
	assign sim_load = out_clk_run && !seq_mode && grp_done_r;
	assign seq_load = out_clk_run && seq_mode && fifo_rvalid;
	assign underrun = out_clk_run && (seq_mode ? !fifo_rvalid : !grp_done_r);
	assign fifo_rready = pop_stage || seq_load;
	assign burst_end_load = sim_load ? stg_burst_r :
		seq_load && fifo_rdata[aout_seq_pkg::ENT_BURST_END];

	always_comb begin
		grp_done_nxt = grp_done_r;
		stg_burst_nxt = stg_burst_r;
		load_nxt = '0;
		for (int i = 0; i < NC; i++) begin
			stage_nxt[i] = stage_r[i];
			dac_nxt[i] = dac_r[i];
		end
		if (idle_st) begin
			grp_done_nxt = 1'b0;
			stg_burst_nxt = 1'b0;
		end else if (pop_stage) begin
			stage_nxt[ent_ch] = fifo_rdata[VW-1:0];
			stg_burst_nxt = stg_burst_r ||
				fifo_rdata[aout_seq_pkg::ENT_BURST_END];
			grp_done_nxt = fifo_rdata[aout_seq_pkg::ENT_GROUP_END];
		end else if (sim_load) begin
			// all four load together from the staged group
			for (int i = 0; i < NC; i++) begin
				dac_nxt[i] = stage_r[i];
			end
			load_nxt = '1;
			grp_done_nxt = 1'b0;
			stg_burst_nxt = 1'b0;
		end
		// group-end bit plays no part on this path
		if (seq_load) begin
			dac_nxt[ent_ch] = fifo_rdata[VW-1:0];
			load_nxt[ent_ch] = 1'b1;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			aout_seq_pkg::ST_IDLE: begin
				if (enable) begin
					st_nxt = burst_mode ? aout_seq_pkg::ST_WAIT_SYNC :
						aout_seq_pkg::ST_RUN;
				end
			end
			aout_seq_pkg::ST_WAIT_SYNC: begin
				if (!enable) begin
					st_nxt = aout_seq_pkg::ST_IDLE;
				end else if (trigger) begin
					st_nxt = aout_seq_pkg::ST_RUN;
				end
			end
			aout_seq_pkg::ST_RUN: begin
				if (!enable) begin
					st_nxt = aout_seq_pkg::ST_IDLE;
				end else if (burst_mode && burst_end_load) begin
					st_nxt = aout_seq_pkg::ST_WAIT_SYNC;
				end
			end
			default: st_nxt = aout_seq_pkg::ST_IDLE;
		endcase
	end

	always_comb begin
		ev = '0;
		ev[aout_seq_pkg::IRQ_LOADED] = sim_load || seq_load;
		ev[aout_seq_pkg::IRQ_BURST_DONE] = running && burst_mode &&
			burst_end_load;
		ev[aout_seq_pkg::IRQ_LOW_LEVEL] = low_level && !low_d_r;
		ev[aout_seq_pkg::IRQ_UNDERRUN] = underrun;
	end

	always_ff @(posedge CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cnt_a_r <= '0;
			cnt_b_r <= '0;
			ext_d_r <= 1'b0;
			low_d_r <= 1'b0;
			SYNC_OUT <= 1'b0;
			st_r <= aout_seq_pkg::ST_IDLE;
			grp_done_r <= 1'b0;
			stg_burst_r <= 1'b0;
			DAC_LOAD <= '0;
			for (int i = 0; i < NC; i++) begin
				stage_r[i] <= '0;
				dac_r[i] <= '0;
			end
		end else begin
			cnt_a_r <= cnt_a_nxt;
			cnt_b_r <= cnt_b_nxt;
			ext_d_r <= EXT_SYNC_IN;
			low_d_r <= low_level;
			SYNC_OUT <= sync_out_nxt;
			st_r <= st_nxt;
			grp_done_r <= grp_done_nxt;
			stg_burst_r <= stg_burst_nxt;
			DAC_LOAD <= load_nxt;
			for (int i = 0; i < NC; i++) begin
				stage_r[i] <= stage_nxt[i];
				dac_r[i] <= dac_nxt[i];
			end
		end
	end
	assign DAC0_DATA = dac_r[0];
	assign DAC1_DATA = dac_r[1];
	assign DAC2_DATA = dac_r[2];
	assign DAC3_DATA = dac_r[3];

	sample_fifo u_fifo (
		.clk(CLK),
		.rst_n(rst_n_r),
		.wr_valid(fifo_wvalid),
		.wr_ready(fifo_wready),
		.wr_data(fifo_wdata),
		.rd_valid(fifo_rvalid),
		.rd_ready(fifo_rready),
		.rd_data(fifo_rdata),
		.level(level)
	);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n_r);

	sequence s_seq_take;
		seq_load ##1 DAC_LOAD != 4'h0;
	endsequence

	chk_group_load_all: assert property (sim_load |=> DAC_LOAD == 4'hf)
		else $error("staged group not loaded to all converters");
	chk_partial_group_hold: assert property (
		(out_clk_run && !seq_mode && !grp_done_r) |=>
		(DAC_LOAD == 4'h0 && $stable(DAC0_DATA) && $stable(DAC3_DATA)))
		else $error("partial group reached converters");
	chk_sw_clock_src: assert property (
		(running && !burst_mode && src == aout_seq_pkg::SRC_SW &&
		sw_pulse_r && !seq_mode && grp_done_r) |=> DAC_LOAD == 4'hf)
		else $error("software flag did not clock the outputs");
	chk_sync_out_drive: assert property (
		(ctrl_r[aout_seq_pkg::CTRL_INITIATOR] && out_clk_run) |=> SYNC_OUT)
		else $error("initiator did not drive sync out");
	chk_burst_wait_sync: assert property (
		(st_r == aout_seq_pkg::ST_WAIT_SYNC && !trigger) |=> !running)
		else $error("burst started without a sync");
	chk_burst_end_stop: assert property (
		(running && burst_mode && enable && burst_end_load) |=>
		st_r == aout_seq_pkg::ST_WAIT_SYNC ##1 DAC_LOAD == 4'h0 ||
		st_r == aout_seq_pkg::ST_WAIT_SYNC)
		else $error("burst did not stop at its end marker");
	chk_seq_direct_route: assert property (
		(seq_load && !sim_load) |=> DAC_LOAD == (4'h1 << $past(ent_ch)))
		else $error("sequential value not routed to its converter");
	chk_seq_no_stage: assert property (seq_mode |-> !pop_stage)
		else $error("sequential mode staged a group");
	chk_seq_take_value: assert property (
		s_seq_take |-> dac_r[$past(ent_ch)] == $past(fifo_rdata[VW-1:0]))
		else $error("converter value differs from the entry");
	chk_low_level_req: assert property (
		(low_level && fifo_wready) |-> DMA_REQ ##1 ($past(level) <= {1'b0,
		$past(thr_r)}))
		else $error("dma request missing below threshold");
	chk_rate_div_wrap: assert property (tick_a |=> cnt_a_r == 16'h0000)
		else $error("rate divider did not wrap");
endmodule // analog_output_sequencer
`default_nettype wire

// ### tb/dma_writer.sv
`timescale 1ns/100ps
`default_nettype none
module dma_writer (
	input wire logic clk,
	input wire logic ready,
	output logic valid,
	output logic [15:0] data
);
	initial begin
		valid = 1'b0;
		data = 16'h0000;
	end
	// gap lets the writer be slow; held until ready is seen at an edge
	task automatic push(input logic [1:0] ch, input logic [11:0] v,
		input logic ge, input logic be, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		valid <= 1'b1;
		data <= {be, ge, ch, v};
		@(posedge clk);
		while (ready !== 1'b1) @(posedge clk);
		valid <= 1'b0;
		// released bus shows the inverse so stale data never looks valid
		data <= ~data;
	endtask
endmodule // dma_writer
`default_nettype wire

// ### tb/analog_output_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module analog_output_sequencer_tb;
	localparam logic [31:0] EN = 32'h1 << aout_seq_pkg::CTRL_ENABLE;
	localparam logic [31:0] SEQ = 32'h1 << aout_seq_pkg::CTRL_SEQ;
	localparam logic [31:0] BST = 32'h1 << aout_seq_pkg::CTRL_BURST;
	localparam logic [31:0] SWS = 32'h1 << aout_seq_pkg::CTRL_SW_SYNC;
	localparam logic [31:0] INI = 32'h1 << aout_seq_pkg::CTRL_INITIATOR;
	localparam logic [31:0] CAS = 32'h1 << aout_seq_pkg::CTRL_CASCADE;
	localparam logic [31:0] SSW =
		32'(aout_seq_pkg::SRC_SW) << aout_seq_pkg::CTRL_SRC_LO;
	localparam logic [31:0] SEX =
		32'(aout_seq_pkg::SRC_EXT) << aout_seq_pkg::CTRL_SRC_LO;
	logic clk, rst_n, psel, penable, pwrite, ext_sync;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, dma_valid, dma_ready, dma_req, sync_out, irq, err;
	logic [15:0] dma_data;
	logic [11:0] dac0, dac1, dac2, dac3;
	logic [3:0] dac_load, last_ld;
	logic last_so;
	int num_errors = 0;
	int checks_done = 0;
	int loads = 0;
	int cyc = 0;
	int last_at = 0;
	analog_output_sequencer dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.DMA_VALID(dma_valid), .DMA_READY(dma_ready), .DMA_DATA(dma_data),
		.DMA_REQ(dma_req), .EXT_SYNC_IN(ext_sync), .SYNC_OUT(sync_out),
		.DAC0_DATA(dac0), .DAC1_DATA(dac1), .DAC2_DATA(dac2),
		.DAC3_DATA(dac3), .DAC_LOAD(dac_load), .IRQ(irq));
	dma_writer writer (.clk(clk), .ready(dma_ready), .valid(dma_valid),
		.data(dma_data));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// load pulses last one cycle, so they are logged at every edge
	always @(posedge clk) begin
		cyc++;
		if (dac_load !== 4'h0) begin
			loads++;
			last_ld = dac_load;
			last_so = sync_out;
			last_at = cyc;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_count(input int n);
		int k;
		k = 0;
		while (loads < n && k < 200) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(loads, n, "load count");
	endtask
	task automatic no_load(input int k);
		int b;
		b = loads;
		repeat (k) @(posedge clk);
		#1;
		chk(loads, b, "unexpected load");
	endtask
	task automatic t_reset();
		apb(1'b0, aout_seq_pkg::OFS_DIV_A, 32'h0);
		chk(rd, 32'h0000ffff, "divider reset");
		apb(1'b0, aout_seq_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0, "control reset");
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, aout_seq_pkg::OFS_DIV_B, 32'h0000a5c3);
		apb(1'b0, aout_seq_pkg::OFS_DIV_B, 32'h0);
		chk(rd, 32'h0000a5c3, "divider write");
		$display("test reset done");
	endtask
	task automatic t_underrun();
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SSW);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SSW | SWS);
		no_load(6);
		apb(1'b0, aout_seq_pkg::OFS_IRQ_STAT, 32'h0);
		chk(rd & 32'h8, 32'h8, "underrun flag");
		chk({31'h0, irq}, 32'h0, "irq masked");
		apb(1'b1, aout_seq_pkg::OFS_IRQ_MASK, 32'h8);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h1, "irq raised");
		apb(1'b1, aout_seq_pkg::OFS_IRQ_STAT, 32'h8);
		@(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'b1, aout_seq_pkg::OFS_IRQ_MASK, 32'h0);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		$display("test underrun done");
	endtask
	task automatic t_simul();
		int b;
		b = loads;
		writer.push(2'd3, 12'hfff, 1'b0, 1'b0, 0);
		writer.push(2'd0, 12'h001, 1'b0, 1'b0, 2);
		writer.push(2'd2, 12'h800, 1'b0, 1'b0, 0);
		writer.push(2'd1, 12'h7fe, 1'b1, 1'b0, 0);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SSW);
		no_load(8);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SSW | SWS);
		wait_count(b + 1);
		chk(32'(last_ld), 32'hf, "group load");
		chk(32'(dac3), 32'hfff, "dac3");
		chk(32'(dac0), 32'h001, "dac0");
		chk(32'(dac2), 32'h800, "dac2");
		chk(32'(dac1), 32'h7fe, "dac1");
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		$display("test simultaneous done");
	endtask
	task automatic t_ext();
		int b;
		b = loads;
		writer.push(2'd1, 12'h5a5, 1'b1, 1'b0, 0);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SEX | INI);
		no_load(6);
		ext_sync <= 1'b1;
		@(posedge clk);
		ext_sync <= 1'b0;
		wait_count(b + 1);
		chk({31'h0, last_so}, 32'h1, "sync out");
		chk(32'(dac1), 32'h5a5, "dac1 ext");
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		$display("test external done");
	endtask
	task automatic t_seq();
		int b;
		int t0;
		apb(1'b1, aout_seq_pkg::OFS_THRESH, 32'h1);
		@(posedge clk);
		#1;
		chk({31'h0, dma_req}, 32'h1, "dma req low level");
		writer.push(2'd2, 12'h123, 1'b1, 1'b0, 0);
		writer.push(2'd1, 12'h456, 1'b0, 1'b0, 0);
		@(posedge clk);
		#1;
		chk({31'h0, dma_req}, 32'h0, "dma req above");
		apb(1'b0, aout_seq_pkg::OFS_LEVEL, 32'h0);
		chk(rd, 32'h2, "level");
		apb(1'b1, aout_seq_pkg::OFS_DIV_A, 32'h7);
		b = loads;
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SEQ);
		wait_count(b + 1);
		t0 = last_at;
		chk(32'(last_ld), 32'h4, "seq first");
		chk(32'(dac2), 32'h123, "seq dac2");
		wait_count(b + 2);
		chk(32'(last_ld), 32'h2, "seq second");
		chk(32'(dac1), 32'h456, "seq dac1");
		chk(last_at - t0, 8, "rate period");
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		$display("test sequential done");
	endtask
	task automatic t_cascade();
		int b;
		int t0;
		apb(1'b1, aout_seq_pkg::OFS_DIV_A, 32'h1);
		apb(1'b1, aout_seq_pkg::OFS_DIV_B, 32'h2);
		writer.push(2'd0, 12'h0a1, 1'b0, 1'b0, 0);
		writer.push(2'd3, 12'h0b2, 1'b0, 1'b0, 0);
		b = loads;
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | SEQ | CAS);
		wait_count(b + 1);
		t0 = last_at;
		chk(32'(dac0), 32'h0a1, "cascade dac0");
		wait_count(b + 2);
		chk(last_at - t0, 6, "cascade period");
		chk(32'(dac3), 32'h0b2, "cascade dac3");
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, aout_seq_pkg::OFS_DIV_A, 32'h7);
		$display("test cascade done");
	endtask
	task automatic t_burst();
		int b;
		int t0;
		writer.push(2'd0, 12'h111, 1'b0, 1'b0, 0);
		writer.push(2'd1, 12'h222, 1'b1, 1'b0, 0);
		writer.push(2'd0, 12'h333, 1'b0, 1'b0, 0);
		writer.push(2'd1, 12'h444, 1'b1, 1'b1, 0);
		writer.push(2'd0, 12'h555, 1'b1, 1'b0, 0);
		b = loads;
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | BST);
		no_load(20);
		apb(1'b1, aout_seq_pkg::OFS_CTRL, EN | BST | SWS);
		wait_count(b + 1);
		t0 = last_at;
		chk(32'(dac0), 32'h111, "burst first");
		wait_count(b + 2);
		chk(last_at - t0, 8, "burst period");
		chk(32'(dac1), 32'h444, "burst last");
		no_load(30);
		apb(1'b0, aout_seq_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h20, 32'h20, "waiting sync");
		apb(1'b1, aout_seq_pkg::OFS_CTRL, 32'h0);
		$display("test burst done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_sync = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_underrun();
		t_simul();
		t_ext();
		t_seq();
		t_cascade();
		t_burst();
		report_and_stop();
	end
endmodule // analog_output_sequencer_tb
`default_nettype wire
